// [logic/ilc_pkg.sv]
// constants, register map and reset values of the io line controller
package ilc_pkg;

    // ------------------------------------------------------------
    // sizes and identity
    // ------------------------------------------------------------
    localparam int          ILC_LINES        = 32;
    localparam logic [7:0]  ILC_ID_FIRST     = 8'h02;
    localparam logic [7:0]  ILC_ID_SECOND    = 8'h03;
    localparam logic [7:0]  ILC_ID_THIRD     = 8'h04;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_GPIO_SET     = 8'h00;
    localparam logic [7:0]  OFF_GPIO_CLR     = 8'h04;
    localparam logic [7:0]  OFF_PERIPHERAL_ASSIGNMENT_STATUS = 8'h08;
    localparam logic [7:0]  OFF_OE_SET       = 8'h10;
    localparam logic [7:0]  OFF_OE_CLR       = 8'h14;
    localparam logic [7:0]  OFF_OE_STAT      = 8'h18;
    localparam logic [7:0]  OFF_FILT_SET     = 8'h20;
    localparam logic [7:0]  OFF_FILT_CLR     = 8'h24;
    localparam logic [7:0]  OFF_FILT_STAT    = 8'h28;
    localparam logic [7:0]  OFF_OUT_SET      = 8'h30;
    localparam logic [7:0]  OFF_OUT_CLR      = 8'h34;
    localparam logic [7:0]  OFF_OUT_DATA     = 8'h38;
    localparam logic [7:0]  OFF_PIN_LEVEL    = 8'h3c;
    localparam logic [7:0]  OFF_IRQ_SET      = 8'h40;
    localparam logic [7:0]  OFF_IRQ_CLR      = 8'h44;
    localparam logic [7:0]  OFF_IRQ_MASK     = 8'h48;
    localparam logic [7:0]  OFF_IRQ_STAT     = 8'h4c;
    localparam logic [7:0]  OFF_MD_SET       = 8'h50;
    localparam logic [7:0]  OFF_MD_CLR       = 8'h54;
    localparam logic [7:0]  OFF_MD_STAT      = 8'h58;
    localparam logic [7:0]  OFF_PU_CLR       = 8'h60;
    localparam logic [7:0]  OFF_PU_SET       = 8'h64;
    localparam logic [7:0]  OFF_PU_STAT      = 8'h68;
    localparam logic [7:0]  OFF_SEL_A        = 8'h70;
    localparam logic [7:0]  OFF_SEL_B        = 8'h74;
    localparam logic [7:0]  OFF_SEL_STAT     = 8'h78;
    localparam logic [7:0]  OFF_OWE_SET      = 8'ha0;
    localparam logic [7:0]  OFF_OWE_CLR      = 8'ha4;
    localparam logic [7:0]  OFF_OWE_STAT     = 8'ha8;
    localparam logic [7:0]  OFF_INST_ID      = 8'hfc;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RST_FUNC_LINES   = 32'h0000_0000;
    localparam logic [31:0] RST_FUNC_SEL_B   = 32'h0000_0000;
    localparam logic [31:0] RST_PULLUP       = 32'hffff_ffff;
    localparam logic [31:0] RST_ZERO         = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam logic [1:0]  CHG_ARM_CYCLES   = 2'h3;

endpackage : ilc_pkg

// [logic/ilc_input_if.sv]
// bundle between the register core and the input stage
`timescale 1ns/10ps
interface ilc_input_if;
    logic [31:0] pad;
    logic [31:0] filter_en;
    logic [31:0] level;
    logic [31:0] change;

    modport stage (input pad, input filter_en, output level, output change);
    modport core  (output pad, output filter_en, input level, input change);
endinterface : ilc_input_if

// [logic/ilc_input_stage.sv]
// synchroniser, glitch filter and change detector for all lines
`timescale 1ns/10ps
module ilc_input_stage
    import ilc_pkg::*;
(
    // clock and reset
    input  wire logic   clk_i,
    input  wire logic   rst_i,
    // lines
    ilc_input_if.stage  in_if
);

    logic [31:0] sync_a;
    logic [31:0] sync_b;
    logic [31:0] sync_c;
    logic [31:0] level;
    logic [31:0] prev;
    logic [1:0]  arm_cnt;
    logic        armed;
    logic        armed_q;

    // ------------------------------------------------------------
    // per-line sampling
    // ------------------------------------------------------------
    for (genvar g = 0; g < ILC_LINES; g++) begin : g_line
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                sync_a[g] <= 1'b0;
                sync_b[g] <= 1'b0;
                sync_c[g] <= 1'b0;
                level[g]  <= 1'b0;
                prev[g]   <= 1'b0;
            end else begin
                sync_a[g] <= in_if.pad[g];
                sync_b[g] <= sync_a[g];
                sync_c[g] <= sync_b[g];
                // filtered lines follow only a level held two samples
                if (!in_if.filter_en[g] || (sync_b[g] == sync_c[g])) begin
                    level[g] <= sync_b[g];
                end
                prev[g] <= level[g];
            end
        end
    end

    // ------------------------------------------------------------
    // change detection, held off while the pipe fills after reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arm_cnt <= 2'h0;
        end else if (!armed) begin
            arm_cnt <= arm_cnt + 2'h1;
        end
    end

    // one more cycle, so prev already holds a real sample of the pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= armed;
        end
    end

    assign armed        = (arm_cnt == CHG_ARM_CYCLES);
    assign in_if.level  = level;
    assign in_if.change = armed_q ? (level ^ prev) : 32'h0000_0000;

endmodule : ilc_input_stage

// [logic/ilc_top.sv]
// io line controller: ahb-lite registers, line mux and interrupt
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/10ps
module ilc_top
    import ilc_pkg::*;
#(
    parameter logic [7:0]  INSTANCE_ID = ILC_ID_FIRST,
    parameter logic [31:0] FUNC_LINES  = RST_FUNC_LINES,
    parameter logic [31:0] FUNC_SEL_B  = RST_FUNC_SEL_B
)(
    // clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        SYS_RST_I,
    // ahb-lite slave
    input  wire logic        HSEL_I,
    input  wire logic [31:0] HADDR_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic [2:0]  HSIZE_I,
    input  wire logic [31:0] HWDATA_I,
    input  wire logic        HREADY_I,
    output logic [31:0]      HRDATA_O,
    output logic             HREADYOUT_O,
    output logic             HRESP_O,
    // pads
    input  wire logic [31:0] PAD_I,
    output logic [31:0]      PAD_O,
    output logic [31:0]      PAD_OE_O,
    output logic [31:0]      PULLUP_EN_O,
    // peripheral functions
    input  wire logic [31:0] PERA_OUT_I,
    input  wire logic [31:0] PERA_OE_I,
    input  wire logic [31:0] PERB_OUT_I,
    input  wire logic [31:0] PERB_OE_I,
    output logic [31:0]      PERIPH_IN_O,
    // interrupt and identity
    output logic             IRQ_O,
    output logic [7:0]       PERIPH_ID_O
);

    logic [31:0] gpio_en;
    logic [31:0] oe_en;
    logic [31:0] filt_en;
    logic [31:0] out_data;
    logic [31:0] irq_mask;
    logic [31:0] irq_stat;
    logic [31:0] md_en;
    logic [31:0] pu_en;
    logic [31:0] sel_b;
    logic [31:0] owe_en;
    logic        wr_pend;
    logic        rd_wait;
    logic [7:0]  reg_addr;
    logic [31:0] rd_val;
    logic [31:0] rdata;
    logic        accept;
    logic [31:0] wd;
    logic [31:0] irq_clr;

    ilc_input_if in_if ();

    // ------------------------------------------------------------
    // input stage
    // ------------------------------------------------------------
    ilc_input_stage u_stage (
        .clk_i (REF_CLK_I),
        .rst_i (SYS_RST_I),
        .in_if (in_if)
    );

    assign in_if.pad       = PAD_I;
    assign in_if.filter_en = filt_en;

    // ------------------------------------------------------------
    // ahb-lite transfer tracking
    // ------------------------------------------------------------
    assign accept = HSEL_I && HTRANS_I[1] && HREADY_I;
    assign wd     = HWDATA_I;

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            wr_pend  <= 1'b0;
            rd_wait  <= 1'b0;
            reg_addr <= 8'h00;
        end else begin
            wr_pend <= accept && HWRITE_I;
            rd_wait <= accept && !HWRITE_I;
            if (accept) begin
                reg_addr <= HADDR_I[7:0];
            end
        end
    end

    function automatic logic wr_at(input logic [7:0] off);
        return wr_pend && (reg_addr == off);
    endfunction : wr_at

    function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic s, input logic c,
                                            input logic [31:0] d);
        return s ? (cur | d) : (c ? (cur & ~d) : cur);
    endfunction : set_clr

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            gpio_en <= ~FUNC_LINES;
        end else begin
            gpio_en <= set_clr(gpio_en, wr_at(OFF_GPIO_SET), wr_at(OFF_GPIO_CLR), wd);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            oe_en <= RST_ZERO;
        end else begin
            oe_en <= set_clr(oe_en, wr_at(OFF_OE_SET), wr_at(OFF_OE_CLR), wd);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            filt_en <= RST_ZERO;
        end else begin
            filt_en <= set_clr(filt_en, wr_at(OFF_FILT_SET), wr_at(OFF_FILT_CLR), wd);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            md_en <= RST_ZERO;
        end else begin
            md_en <= set_clr(md_en, wr_at(OFF_MD_SET), wr_at(OFF_MD_CLR), wd);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            pu_en <= RST_PULLUP;
        end else begin
            pu_en <= set_clr(pu_en, wr_at(OFF_PU_SET), wr_at(OFF_PU_CLR), wd);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            sel_b <= FUNC_SEL_B;
        end else begin
            sel_b <= set_clr(sel_b, wr_at(OFF_SEL_B), wr_at(OFF_SEL_A), wd);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            owe_en <= RST_ZERO;
        end else begin
            owe_en <= set_clr(owe_en, wr_at(OFF_OWE_SET), wr_at(OFF_OWE_CLR), wd);
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            irq_mask <= RST_ZERO;
        end else begin
            irq_mask <= set_clr(irq_mask, wr_at(OFF_IRQ_SET), wr_at(OFF_IRQ_CLR), wd);
        end
    end

    // ------------------------------------------------------------
    // output data, with masked direct write
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            out_data <= RST_ZERO;
        end else if (wr_at(OFF_OUT_DATA)) begin
            out_data <= (out_data & ~owe_en) | (wd & owe_en);
        end else begin
            out_data <= set_clr(out_data, wr_at(OFF_OUT_SET), wr_at(OFF_OUT_CLR), wd);
        end
    end

    // ------------------------------------------------------------
    // change status: read or write-one clears, new change wins
    // ------------------------------------------------------------
    always_comb begin
        irq_clr = 32'h0000_0000;
        if (rd_wait && (reg_addr == OFF_IRQ_STAT)) begin
            irq_clr = 32'hffff_ffff;
        end else if (wr_at(OFF_IRQ_STAT)) begin
            irq_clr = wd;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            irq_stat <= RST_ZERO;
        end else begin
            irq_stat <= (irq_stat & ~irq_clr) | in_if.change;
        end
    end

    assign IRQ_O = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // read path, one wait state
    // ------------------------------------------------------------
    always_comb begin
        unique case (reg_addr)
            OFF_PERIPHERAL_ASSIGNMENT_STATUS: rd_val = ~gpio_en;
            OFF_GPIO_SET:  rd_val = gpio_en;
            OFF_OE_STAT:   rd_val = oe_en;
            OFF_FILT_STAT: rd_val = filt_en;
            OFF_OUT_DATA:  rd_val = out_data;
            OFF_PIN_LEVEL: rd_val = in_if.level;
            OFF_IRQ_MASK:  rd_val = irq_mask;
            OFF_IRQ_STAT:  rd_val = irq_stat;
            OFF_MD_STAT:   rd_val = md_en;
            OFF_PU_STAT:   rd_val = pu_en;
            OFF_SEL_STAT:  rd_val = sel_b;
            OFF_OWE_STAT:  rd_val = owe_en;
            OFF_INST_ID:   rd_val = {24'h000000, INSTANCE_ID};
            default:       rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            rdata <= 32'h0000_0000;
        end else if (rd_wait) begin
            rdata <= rd_val;
        end
    end

    assign HRDATA_O    = rdata;
    assign HREADYOUT_O = !rd_wait;
    assign HRESP_O     = 1'b0;

    // ------------------------------------------------------------
    // line multiplexer and pad drive
    // ------------------------------------------------------------
    for (genvar g = 0; g < ILC_LINES; g++) begin : g_pad
        logic per_out;
        logic per_oe;
        logic drv_val;
        logic drv_en;

        assign per_out = sel_b[g] ? PERB_OUT_I[g] : PERA_OUT_I[g];
        assign per_oe  = sel_b[g] ? PERB_OE_I[g] : PERA_OE_I[g];
        assign drv_val = gpio_en[g] ? out_data[g] : per_out;
        assign drv_en  = gpio_en[g] ? oe_en[g] : per_oe;

        // multi-drive lines drive only a low level
        assign PAD_O[g]    = drv_val && !md_en[g];
        assign PAD_OE_O[g] = drv_en && !(md_en[g] && drv_val);
    end

    assign PULLUP_EN_O = pu_en;
    assign PERIPH_IN_O = in_if.level;
    assign PERIPH_ID_O = INSTANCE_ID;

endmodule : ilc_top

// [tb/ilc_checker.sv]
// port-level assertions for the io line controller
`timescale 1ns/10ps
module ilc_checker
    import ilc_pkg::*;
#(
    parameter logic [7:0]  INSTANCE_ID = ILC_ID_FIRST,
    parameter logic [31:0] FUNC_LINES  = RST_FUNC_LINES,
    parameter logic [31:0] FUNC_SEL_B  = RST_FUNC_SEL_B
)(
    // clock and reset
    input  wire logic        REF_CLK_I,
    input  wire logic        SYS_RST_I,
    // bus
    input  wire logic        HSEL_I,
    input  wire logic [1:0]  HTRANS_I,
    input  wire logic        HWRITE_I,
    input  wire logic        HREADY_I,
    input  wire logic        HREADYOUT_O,
    input  wire logic        HRESP_O,
    // lines and interrupt
    input  wire logic [31:0] PAD_OE_O,
    input  wire logic [31:0] PULLUP_EN_O,
    input  wire logic [31:0] PERA_OE_I,
    input  wire logic [31:0] PERB_OE_I,
    input  wire logic        IRQ_O,
    input  wire logic [7:0]  PERIPH_ID_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic acc;
    assign acc = HSEL_I && HTRANS_I[1] && HREADY_I;

    periph_id_a: assert property (PERIPH_ID_O == INSTANCE_ID)
        else $error("identifier differs from parameter");
    reset_pullup_a: assert property ($past(SYS_RST_I) |-> PULLUP_EN_O == 32'hffff_ffff)
        else $error("pull-ups not all on after reset");
    reset_input_a: assert property ($past(SYS_RST_I) |-> (PAD_OE_O & ~FUNC_LINES) == 32'h0)
        else $error("gpio line driven after reset");
    reset_func_a: assert property ($past(SYS_RST_I) |-> (PAD_OE_O & FUNC_LINES) ==
        (FUNC_LINES & ((FUNC_SEL_B & PERB_OE_I) | (~FUNC_SEL_B & PERA_OE_I))))
        else $error("function line not following its peripheral after reset");
    irq_fall_a: assert property ($fell(IRQ_O) |-> $past(acc, 2))
        else $error("interrupt dropped without a bus access");
    pullup_cause_a: assert property ($changed(PULLUP_EN_O) |-> $past(acc && HWRITE_I, 2))
        else $error("pull-up changed without a write");
    read_wait_a: assert property (acc && !HWRITE_I |=> !HREADYOUT_O ##1 HREADYOUT_O)
        else $error("read wait not exactly one cycle");
    write_nowait_a: assert property (acc && HWRITE_I |=> HREADYOUT_O)
        else $error("write stalled");
    resp_okay_a: assert property (HRESP_O == 1'b0)
        else $error("error response");
endmodule : ilc_checker

bind ilc_top ilc_checker #(
    .INSTANCE_ID(INSTANCE_ID), .FUNC_LINES(FUNC_LINES), .FUNC_SEL_B(FUNC_SEL_B)
) u_ilc_checker (
    .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
    .PAD_OE_O(PAD_OE_O), .PULLUP_EN_O(PULLUP_EN_O), .PERA_OE_I(PERA_OE_I),
    .PERB_OE_I(PERB_OE_I), .IRQ_O(IRQ_O), .PERIPH_ID_O(PERIPH_ID_O)
);

// [tb/ilc_pad_model.sv]
// board side of the pads: external drivers, pull-ups, floating lines
`timescale 1ns/10ps
module ilc_pad_model (
    // clock
    input  wire logic        clk_i,
    // from the controller
    input  wire logic [31:0] drv_i,
    input  wire logic [31:0] drv_en_i,
    input  wire logic [31:0] pu_en_i,
    // external devices
    input  wire logic [31:0] ext_i,
    input  wire logic [31:0] ext_en_i,
    // resulting pad level
    output logic [31:0]      level_o
);
    logic [31:0] last;
    always_ff @(posedge clk_i) begin
        last <= level_o;
    end
    // floating lines without pull-up toggle every cycle
    assign level_o = (drv_en_i & drv_i) | (~drv_en_i & ext_en_i & ext_i)
                   | (~drv_en_i & ~ext_en_i & pu_en_i)
                   | (~drv_en_i & ~ext_en_i & ~pu_en_i & ~last);
endmodule : ilc_pad_model

// [tb/tb_io_line_controller_with_mux.sv]
// self-checking bench for the io line controller
`timescale 1ns/10ps
module tb_io_line_controller_with_mux
    import ilc_pkg::*;
;
    logic        clk, rst, hsel, hwrite, rd_ph, hrdy, hresp, irq;
    logic [1:0]  htrans;
    logic [7:0]  pid;
    logic [31:0] haddr, hwdata, hrdata, pad_o, pad_oe, pu, pin, pin_in;
    logic [31:0] pa, pao, pb, pbo, ext, ext_en, r, m, d, v, e, p;
    logic [31:0] q[$];
    int          miscompares, samples_checked, cyc;

    ilc_top #(
        .INSTANCE_ID(ILC_ID_SECOND), .FUNC_LINES(32'hc000_0000), .FUNC_SEL_B(32'h8000_0000)
    ) u_ilc_top (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
        .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp), .PAD_I(pin),
        .PAD_O(pad_o), .PAD_OE_O(pad_oe), .PULLUP_EN_O(pu), .PERA_OUT_I(pa),
        .PERA_OE_I(pao), .PERB_OUT_I(pb), .PERB_OE_I(pbo), .PERIPH_IN_O(pin_in),
        .IRQ_O(irq), .PERIPH_ID_O(pid)
    );
    ilc_pad_model u_ilc_pad_model (
        .clk_i(clk), .drv_i(pad_o), .drv_en_i(pad_oe), .pu_en_i(pu),
        .ext_i(ext), .ext_en_i(ext_en), .level_o(pin)
    );

    // ----------------------------------------
    // bus tasks and checking
    // ----------------------------------------
    task automatic cmp(input string n, input logic [31:0] x, input logic [31:0] g);
        samples_checked++;
        if (g !== x) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, x, g);
        end
    endtask : cmp

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        rd_ph <= !w;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        rd_ph <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        bus(1'b1, a, wd);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        q.push_back(x);
        bus(1'b0, a, 32'h0);
    endtask : rd

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        if (rd_ph && hrdy === 1'b1) cmp("read data", q.pop_front(), hrdata);
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            miscompares++;
            finish_test();
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(19));
        rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; rd_ph = 1'b0; htrans = 2'h0;
        haddr = 32'h0; hwdata = 32'h0; ext = 32'h0; ext_en = 32'h0;
        pa = $urandom; pao = $urandom; pb = $urandom; pbo = $urandom;
        r = $urandom; m = $urandom; d = $urandom; e = $urandom;
        v = (r & ~m) | (d & m);
        p = 32'h0000_fff0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        cmp("pull-up", 32'hffff_ffff, pu);
        rd(8'h08, 32'hc000_0000);
        rd(8'h68, 32'hffff_ffff);
        rd(8'h18, 32'h0);
        rd(8'hfc, {24'h0, ILC_ID_SECOND});
        cmp("identifier", {24'h0, ILC_ID_SECOND}, {24'h0, pid});
        rd(8'hc0, 32'h0);
        rd(8'h4c, 32'h0);
        wr(8'h00, 32'hffff_ffff);
        rd(8'h08, 32'h0);
        wr(8'h10, 32'hffff_ffff);
        wr(8'h34, 32'hffff_ffff);
        wr(8'h30, r);
        wr(8'ha0, m);
        rd(8'ha8, m);
        wr(8'h38, d);
        rd(8'h38, v);
        cmp("pad out", v, pad_o);
        wr(8'h50, m);
        @(negedge clk);
        cmp("pad out", v & ~m, pad_o);
        cmp("pad enable", ~m | ~v, pad_oe);
        @(posedge clk);
        rd(8'h58, m);
        wr(8'h54, 32'hffff_ffff);
        wr(8'h60, m);
        rd(8'h68, ~m);
        cmp("pull-up", ~m, pu);
        wr(8'h64, m);
        wr(8'h04, p);
        wr(8'h74, 32'h0000_ff00);
        wr(8'h70, 32'h0000_00f0);
        rd(8'h08, p);
        rd(8'h78, 32'h8000_ff00);
        cmp("pad out", (v & ~p) | (pa & 32'h00f0) | (pb & 32'hff00), pad_o);
        cmp("pad enable", ~p | (pao & 32'h00f0) | (pbo & 32'hff00), pad_oe);
        pao <= 32'h0;
        pbo <= 32'h0;
        ext <= e;
        ext_en <= 32'hffff_ffff;
        wr(8'h14, 32'hffff_ffff);
        repeat (5) @(posedge clk);
        rd(8'h3c, e);
        cmp("peripheral input", e, pin_in);
        wr(8'h4c, 32'hffff_ffff);
        rd(8'h4c, 32'h0);
        wr(8'h40, 32'h21);
        ext <= e ^ 32'h21;
        repeat (6) @(posedge clk);
        cmp("irq", 32'h1, {31'h0, irq});
        rd(8'h4c, 32'h21);
        cmp("irq", 32'h0, {31'h0, irq});
        wr(8'h20, 32'h2);
        ext <= e ^ 32'h23;
        @(posedge clk);
        ext <= e ^ 32'h21;
        repeat (8) @(posedge clk);
        rd(8'h4c, 32'h0);
        rd(8'h28, 32'h2);
        wr(8'h44, 32'h21);
        ext <= e;
        repeat (6) @(posedge clk);
        cmp("irq", 32'h0, {31'h0, irq});
        rd(8'h48, 32'h0);
        rd(8'h4c, 32'h21);
        repeat (2) @(posedge clk);
        finish_test();
    end
endmodule : tb_io_line_controller_with_mux
